// ==== tmc_pkg.sv ====
// shared constants and types of the transceiver mode controller
package tmc_pkg;
	// clock and time base
	localparam int CLK_PERIOD_NS        = 50;
	localparam int FAIL_SAFE_TIMEOUT_NS = 4000000;   // fail_safe_timeout
	localparam int UV_FILTER_NS         = 200000;    // undervoltage_filter_time
	localparam int MODE_HOLD_NS         = 20000;     // mode_hold_time
	localparam int SLEEP_ENTRY_NS       = 10000;     // sleep_entry_time
	// least times, rounded up to whole cycles
	localparam int FAIL_SAFE_CYC   = (FAIL_SAFE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UV_FILTER_CYC   = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_HOLD_CYC   = (MODE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 20;                 // wide enough for every count
	// operating modes
	typedef enum logic [2:0] {
		modeOff,
		modeSleep,
		modeStandby,
		modeGoSleep,
		modeSilent,
		modeNormal
	} tmc_mode_t;
	// host register map
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_STATUS    = 8'h04;
	localparam int          CTRL_STB_BIT  = 0;        // standby_select_n level
	localparam int          CTRL_EN_BIT   = 1;        // enable level
	localparam int          CTRL_HOLD_BIT = 2;        // power_request_hold_off level
	localparam logic [2:0]  CTRL_RESET    = 3'h0;
	localparam int          STAT_RXD_BIT  = 0;        // synchronised receive line
	localparam int          STAT_PEND_BIT = 1;        // standby-select rise waiting
endpackage : tmc_pkg

// ==== tmc_pin_if.sv ====
// pin-level link between host controller and transceiver
`timescale 1ns/10ps
interface tmc_pin_if;
	logic standbySelectN;       // mode pin, active low standby
	logic enable;               // mode pin
	logic powerRequestHoldOff;  // hold-off input to device
	logic rxdOut;               // device receive data value
	logic rxdOe;                // device drives receive line
	logic rxdLine;              // resolved receive line

	// undriven receive line reads high, as with the host's pull-up
	assign rxdLine = rxdOe ? rxdOut : 1'b1;

	modport device (
		input  standbySelectN,
		input  enable,
		input  powerRequestHoldOff,
		output rxdOut,
		output rxdOe
	);
	modport host (
		output standbySelectN,
		output enable,
		output powerRequestHoldOff,
		input  rxdLine
	);
endinterface : tmc_pin_if

// ==== tmc_pin_sync.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module tmc_pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	// pins in, filtered levels out
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	logic [W-1:0] stage1_r;   // metastable stage, read only by stage2
	logic [W-1:0] stage2_r;
	logic [W-1:0] stage3_r;
	logic [W-1:0] level_r;

	// a change counts only once stage two and three agree
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stage1_r <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
			level_r  <= '0;
		end else begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			level_r  <= (stage2_r & stage3_r) | (level_r & (stage2_r | stage3_r));
		end
	end

	assign pinOut = level_r;
endmodule : tmc_pin_sync

// ==== tmc_device.sv ====
// transceiver operating-mode state machine (device end)
// Summary of operation
// - six modes chosen from pins and conditions
// - undervoltage timers armed after first rise
// - armed timer past filter forces sleep
// - fail-safe timer starts on standby entry
// - normal entry stops and clears fail-safe
// - silent from standby keeps timer running
// - standby-select rise exits plain sleep
// - pin exits need io supply valid
// - fail-safe sleep exits on enable edge
// - host first toggles enable with select low
// - select held low mode hold time
// - hold-off latched only in silent mode
// - battery undervoltage clears hold-off latch
// - enable high, select low is go-to-sleep
// - sleep-entry expiry moves into sleep
// - power request stays until sleep entry
// - normal enables driver and receiver
// - silent disables driver, keeps receiver
// - standby drives receive low on wake
// - normal entry clears wake, power-on flags
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module tmc_device #(
	parameter int FAIL_SAFE_CYCLES = tmc_pkg::FAIL_SAFE_CYC
) (
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	// pins from the host
	tmc_pin_if.device          pins,
	// supply, temperature and wake status, all asynchronous
	input  wire logic          batteryUndervoltage,
	input  wire logic          coreSupplyAboveRise,
	input  wire logic          coreSupplyBelowFall,
	input  wire logic          ioSupplyAboveRise,
	input  wire logic          ioSupplyBelowFall,
	input  wire logic          thermalShutdown,
	input  wire logic          wakeEvent,
	input  wire logic          busRecessive,
	// bus-side controls and status
	output logic               driverEn,
	output logic               receiverEn,
	output logic               busMonitorEn,
	output logic               powerRequestOut,
	output logic               powerRequestOe,
	output logic               wakeRequestFlag,
	output logic               powerOnFlag,
	output logic               holdOffLatched,
	output tmc_pkg::tmc_mode_t modeState
);
	localparam int NSYNC = 11;

	logic [NSYNC-1:0]            syncIn;         // raw asynchronous levels
	logic [NSYNC-1:0]            syncOut;        // filtered levels
	logic                        stbN, en, holdIn, batUv, tsd, wakeIn, busRec;
	logic [1:0]                  supRise;        // core, io above rising threshold
	logic [1:0]                  supFall;        // core, io below falling threshold
	tmc_pkg::tmc_mode_t          mode_r, mode_nxt;
	logic                        stbPrev_r, enPrev_r;
	logic                        stbRise, enRise, enFall, enEdge;
	logic [1:0]                  uvArmed_r;
	logic [tmc_pkg::CNT_W-1:0]   uvCnt_r [2];
	logic [1:0]                  uvExp;
	logic                        uvExpired;
	logic [tmc_pkg::CNT_W-1:0]   failCnt_r;
	logic                        failRun, failExpired;
	logic                        silentFromStandby_r;
	logic [tmc_pkg::CNT_W-1:0]   gsCnt_r;
	logic                        gsDone;
	logic                        failSafeSleep_r;
	logic                        seqReady_r, holdRun_r;
	logic [tmc_pkg::CNT_W-1:0]   holdCnt_r;
	logic                        enterNormal, enterSleep, enterSilent;
	logic                        wakeFlag_r, wakeFlag_nxt, power_on_flag_r, power_on_flag_nxt;
	logic                        hold_r, rxdOut_r;

	// true where the power request output is on
	function automatic logic inhActive(input tmc_pkg::tmc_mode_t m);
		return (m == tmc_pkg::modeStandby) || (m == tmc_pkg::modeGoSleep) ||
		       (m == tmc_pkg::modeSilent) || (m == tmc_pkg::modeNormal);
	endfunction : inhActive

	// every pin and status input crosses into the clock domain
	assign syncIn = {pins.standbySelectN, pins.enable, pins.powerRequestHoldOff, batteryUndervoltage,
	                 coreSupplyAboveRise, coreSupplyBelowFall, ioSupplyAboveRise, ioSupplyBelowFall,
	                 thermalShutdown, wakeEvent, busRecessive};
	tmc_pin_sync #(.W(NSYNC)) uSync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.pinIn   (syncIn),
		.pinOut  (syncOut)
	);
	assign {stbN, en, holdIn, batUv, supRise[0], supFall[0], supRise[1], supFall[1], tsd, wakeIn, busRec} = syncOut;

	// pin edges
	assign stbRise = stbN & ~stbPrev_r;
	assign enRise  = en & ~enPrev_r;
	assign enFall  = ~en & enPrev_r;
	assign enEdge  = en ^ enPrev_r;

	// core and io undervoltage filter timers
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gUv
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					uvArmed_r[g] <= 1'b0;
					uvCnt_r[g]   <= '0;
				end else begin
					if (supRise[g])
						uvArmed_r[g] <= 1'b1;
					if (!(uvArmed_r[g] && supFall[g]))
						uvCnt_r[g] <= '0;
					else if (!uvExp[g])
						uvCnt_r[g] <= uvCnt_r[g] + 1'b1;
				end
			end
			assign uvExp[g] = (uvCnt_r[g] == tmc_pkg::CNT_W'(tmc_pkg::UV_FILTER_CYC));
		end
	endgenerate
	assign uvExpired = |uvExp;

	// fail-safe runs in standby and in silent reached from standby
	assign failRun     = (mode_r == tmc_pkg::modeStandby) ||
	                     (mode_r == tmc_pkg::modeSilent && silentFromStandby_r);
	assign failExpired = failRun && (failCnt_r >= tmc_pkg::CNT_W'(FAIL_SAFE_CYCLES));
	assign gsDone      = (gsCnt_r == tmc_pkg::CNT_W'(tmc_pkg::SLEEP_ENTRY_CYC - 1));

	// mode selection; fault conditions override the pins
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			tmc_pkg::modeOff: begin
				mode_nxt = tmc_pkg::modeStandby;
			end
			tmc_pkg::modeStandby: begin
				if (stbN)
					mode_nxt = en ? tmc_pkg::modeNormal : tmc_pkg::modeSilent;
				else if (en && !wakeFlag_r)
					mode_nxt = tmc_pkg::modeGoSleep;
			end
			tmc_pkg::modeSilent, tmc_pkg::modeNormal: begin
				if (!stbN)
					mode_nxt = en ? tmc_pkg::modeGoSleep : tmc_pkg::modeStandby;
				else
					mode_nxt = en ? tmc_pkg::modeNormal : tmc_pkg::modeSilent;
			end
			tmc_pkg::modeGoSleep: begin
				if (gsDone)
					mode_nxt = tmc_pkg::modeSleep;
				else if (stbN)
					mode_nxt = en ? tmc_pkg::modeNormal : tmc_pkg::modeSilent;
				else if (!en)
					mode_nxt = tmc_pkg::modeStandby;
			end
			tmc_pkg::modeSleep: begin
				if (wakeIn)
					mode_nxt = tmc_pkg::modeStandby;
				else if (supRise[1]) begin
					if (!failSafeSleep_r && stbRise)
						mode_nxt = en ? tmc_pkg::modeNormal : tmc_pkg::modeSilent;
					else if (failSafeSleep_r && seqReady_r && stbN && enRise)
						mode_nxt = tmc_pkg::modeNormal;
					else if (failSafeSleep_r && seqReady_r && stbN && enFall)
						mode_nxt = tmc_pkg::modeSilent;
				end
			end
			default: mode_nxt = tmc_pkg::modeOff;
		endcase
		if (failExpired)
			mode_nxt = tmc_pkg::modeSleep;
		if (uvExpired && mode_r != tmc_pkg::modeSleep && mode_r != tmc_pkg::modeOff)
			mode_nxt = tmc_pkg::modeSleep;
		if (batUv)
			mode_nxt = tmc_pkg::modeOff;
	end

	assign enterNormal = (mode_nxt == tmc_pkg::modeNormal) && (mode_r != tmc_pkg::modeNormal);
	assign enterSleep  = (mode_nxt == tmc_pkg::modeSleep) && (mode_r != tmc_pkg::modeSleep);
	assign enterSilent = (mode_nxt == tmc_pkg::modeSilent) && (mode_r != tmc_pkg::modeSilent);

	// flags: a set in the same cycle as a clear wins
	assign wakeFlag_nxt = (wakeIn && (mode_r == tmc_pkg::modeStandby || mode_r == tmc_pkg::modeSleep)) ||
	                      (wakeFlag_r && !enterNormal);
	assign power_on_flag_nxt    = (mode_r == tmc_pkg::modeOff && mode_nxt != tmc_pkg::modeOff) ||
	                      (power_on_flag_r && !enterNormal);

	// mode register, pin history and flags
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode_r     <= tmc_pkg::modeOff;
			stbPrev_r  <= 1'b0;
			enPrev_r   <= 1'b0;
			wakeFlag_r <= 1'b0;
			power_on_flag_r    <= 1'b0;
		end else begin
			mode_r     <= mode_nxt;
			stbPrev_r  <= stbN;
			enPrev_r   <= en;
			wakeFlag_r <= wakeFlag_nxt;
			power_on_flag_r    <= power_on_flag_nxt;
		end
	end

	// fail-safe and sleep-entry timers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			failCnt_r           <= '0;
			silentFromStandby_r <= 1'b0;
			gsCnt_r             <= '0;
		end else begin
			// cleared whenever idle, so normal entry stops and clears it
			failCnt_r <= (failRun && !failExpired) ? failCnt_r + 1'b1 : '0;
			if (enterSilent)
				silentFromStandby_r <= (mode_r == tmc_pkg::modeStandby);
			gsCnt_r <= (mode_r == tmc_pkg::modeGoSleep && !gsDone) ? gsCnt_r + 1'b1 : '0;
		end
	end

	// exit sequence after fail-safe sleep
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			failSafeSleep_r <= 1'b0;
			seqReady_r      <= 1'b0;
			holdRun_r       <= 1'b0;
			holdCnt_r       <= '0;
		end else if (enterSleep) begin
			failSafeSleep_r <= failExpired;
			seqReady_r      <= !stbN;                     // select already high needs a fresh edge
			holdRun_r       <= 1'b0;
			holdCnt_r       <= '0;
		end else if (!stbN && enEdge) begin
			seqReady_r <= 1'b0;                           // edge with select low restarts hold
			holdRun_r  <= 1'b1;
			holdCnt_r  <= '0;
		end else if (holdRun_r && !stbN) begin
			holdCnt_r <= holdCnt_r + 1'b1;
			if (holdCnt_r == tmc_pkg::CNT_W'(tmc_pkg::MODE_HOLD_CYC - 1)) begin
				seqReady_r <= 1'b1;
				holdRun_r  <= 1'b0;
			end
		end else if (holdRun_r && stbN) begin
			holdRun_r <= 1'b0;                            // select rose too early, ignored
		end
	end

	// hold-off latch and receive output
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hold_r   <= 1'b0;
			rxdOut_r <= 1'b1;
		end else begin
			if (batUv)
				hold_r <= 1'b0;
			else if (mode_r == tmc_pkg::modeSilent)
				hold_r <= holdIn;
			case (mode_nxt)
				tmc_pkg::modeNormal, tmc_pkg::modeSilent: rxdOut_r <= busRec;
				tmc_pkg::modeStandby: rxdOut_r <= !wakeFlag_nxt;
				default: rxdOut_r <= 1'b1;
			endcase
		end
	end

	// mode-decoded outputs
	assign driverEn        = (mode_r == tmc_pkg::modeNormal) && !tsd;
	assign receiverEn      = (mode_r == tmc_pkg::modeNormal) || (mode_r == tmc_pkg::modeSilent);
	assign busMonitorEn    = (mode_r == tmc_pkg::modeStandby) || (mode_r == tmc_pkg::modeGoSleep) ||
	                         (mode_r == tmc_pkg::modeSleep);
	// the mask suppresses the request only in standby, e.g. after a spurious wake
	assign powerRequestOe  = inhActive(mode_r) && !(hold_r && mode_r == tmc_pkg::modeStandby);
	assign powerRequestOut = 1'b1;
	assign pins.rxdOut     = rxdOut_r;
	assign pins.rxdOe      = (mode_r != tmc_pkg::modeOff) && supRise[1];
	assign wakeRequestFlag = wakeFlag_r;
	assign powerOnFlag     = power_on_flag_r;
	assign holdOffLatched  = hold_r;
	assign modeState       = mode_r;
endmodule : tmc_device

// ==== tmc_host.sv ====
// host end: drives the mode pins from AHB-Lite registers
`timescale 1ns/10ps
module tmc_host (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// pins to the device
	tmc_pin_if.host          pins
);
	logic                      addrPhase;     // valid address phase this cycle
	logic                      wrPend_r;      // write data phase pending
	logic [7:0]                addr_r;
	logic [2:0]                ctrl_r;        // requested pin levels
	logic [31:0]               hrdata_r;
	logic [31:0]               readMux;
	logic                      rxdLevel;
	logic                      stbPin_r, enPin_r, holdPin_r;
	logic [tmc_pkg::CNT_W-1:0] holdCnt_r;
	logic                      holdDone, stbPending;

	// receive line is a pin from the far end
	tmc_pin_sync #(.W(1)) uRxdSync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.pinIn   (pins.rxdLine),
		.pinOut  (rxdLevel)
	);

	// bus decode; every transfer answers with no wait state
	assign addrPhase  = hsel && htrans[1] && hready;
	assign holdDone   = (holdCnt_r >= tmc_pkg::CNT_W'(tmc_pkg::MODE_HOLD_CYC));
	assign stbPending = ctrl_r[tmc_pkg::CTRL_STB_BIT] && !stbPin_r;
	assign readMux    = (haddr[7:0] == tmc_pkg::REG_CTRL)   ? {29'h0, ctrl_r} :
	                    (haddr[7:0] == tmc_pkg::REG_STATUS) ? {30'h0, stbPending, rxdLevel} : 32'h0;

	// register writes land in the data phase; read data is captured at the address edge
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wrPend_r <= 1'b0;
			addr_r   <= 8'h00;
			ctrl_r   <= tmc_pkg::CTRL_RESET;
			hrdata_r <= 32'h0;
		end else begin
			wrPend_r <= addrPhase && hwrite;
			if (addrPhase)
				addr_r <= haddr[7:0];
			if (addrPhase && !hwrite)
				hrdata_r <= readMux;
			if (wrPend_r && addr_r == tmc_pkg::REG_CTRL)
				ctrl_r <= hwdata[2:0];
		end
	end

	// pins follow the register, so software can walk any exit sequence
	// a select rise waits out the hold time after an enable edge
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stbPin_r  <= 1'b0;
			enPin_r   <= 1'b0;
			holdPin_r <= 1'b0;
			holdCnt_r <= tmc_pkg::CNT_W'(tmc_pkg::MODE_HOLD_CYC);
		end else begin
			enPin_r   <= ctrl_r[tmc_pkg::CTRL_EN_BIT];
			holdPin_r <= ctrl_r[tmc_pkg::CTRL_HOLD_BIT];
			if (enPin_r != ctrl_r[tmc_pkg::CTRL_EN_BIT] && !stbPin_r)
				holdCnt_r <= '0;
			else if (!holdDone)
				holdCnt_r <= holdCnt_r + 1'b1;
			if (!ctrl_r[tmc_pkg::CTRL_STB_BIT])
				stbPin_r <= 1'b0;
			else if (holdDone)
				stbPin_r <= 1'b1;
		end
	end

	assign hreadyout                = 1'b1;
	assign hresp                    = 1'b0;
	assign hrdata                   = hrdata_r;
	assign pins.standbySelectN      = stbPin_r;
	assign pins.enable              = enPin_r;
	assign pins.powerRequestHoldOff = holdPin_r;   // software sets it in silent mode
endmodule : tmc_host

// ==== tmc_mode_monitor.sv ====
// concurrent checks on the pin link and the device mode outputs
`timescale 1ns/10ps
module tmc_mode_monitor #(
	parameter int FAIL_SAFE_CYCLES = tmc_pkg::FAIL_SAFE_CYC
) (
	// clock and reset
	input wire logic               ref_clk,
	input wire logic               rstn,
	// pin link
	input wire logic               standbySelectN,
	input wire logic               enable,
	input wire logic               rxdOut,
	input wire logic               rxdOe,
	// device status
	input wire logic               batteryUndervoltage,
	input wire logic               driverEn,
	input wire logic               receiverEn,
	input wire logic               busMonitorEn,
	input wire logic               powerRequestOe,
	input wire logic               wakeRequestFlag,
	input wire logic               powerOnFlag,
	input wire logic               holdOffLatched,
	input wire tmc_pkg::tmc_mode_t modeState
);
	localparam int GS = tmc_pkg::SLEEP_ENTRY_CYC;  // go-to-sleep length
	logic [19:0] gsCnt_r;    // cycles spent in go-to-sleep
	logic [19:0] gsCnt_nxt;
	logic [19:0] fsCnt_r;    // fail-safe age since standby entry
	logic [19:0] fsCnt_nxt;
	wire         inGs  = modeState == tmc_pkg::modeGoSleep;
	wire         fsClr = modeState inside {tmc_pkg::modeNormal, tmc_pkg::modeSleep, tmc_pkg::modeOff};
	// silent from normal never starts counting, silent from standby keeps on
	wire         fsRun = modeState == tmc_pkg::modeStandby || fsCnt_r != 20'h0;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	assign gsCnt_nxt = inGs ? gsCnt_r + 20'h1 : 20'h0;
	assign fsCnt_nxt = fsClr ? 20'h0 : (fsRun ? fsCnt_r + 20'h1 : fsCnt_r);

	// helper counters, kept short
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gsCnt_r <= 20'h0;
			fsCnt_r <= 20'h0;
		end else begin
			gsCnt_r <= gsCnt_nxt;
			fsCnt_r <= fsCnt_nxt;
		end
	end

	a_fail_safe_bound: assert property (int'(fsCnt_r) <= FAIL_SAFE_CYCLES + 8)
		else $error("fail-safe timer overran");
	a_fail_safe_early: assert property (modeState == tmc_pkg::modeSleep &&
		$past(modeState) inside {tmc_pkg::modeStandby, tmc_pkg::modeSilent} |-> int'($past(fsCnt_r)) >= FAIL_SAFE_CYCLES - 8)
		else $error("fail-safe sleep came too early");
	a_gosleep_length: assert property ($past(inGs) && modeState == tmc_pkg::modeSleep |->
		int'($past(gsCnt_r)) inside {[GS - 2:GS + 1]}) else $error("go-to-sleep length wrong");
	a_gosleep_request: assert property (inGs |-> powerRequestOe && !driverEn)
		else $error("request dropped in go-to-sleep");
	a_sleep_released: assert property (modeState inside {tmc_pkg::modeSleep, tmc_pkg::modeOff} |->
		!powerRequestOe && !driverEn && !receiverEn) else $error("request or driver on in sleep");
	a_receiver_modes: assert property (receiverEn == (modeState inside {tmc_pkg::modeNormal, tmc_pkg::modeSilent}))
		else $error("receiver enable wrong");
	a_driver_normal: assert property (driverEn |-> modeState == tmc_pkg::modeNormal)
		else $error("driver on outside normal");
	a_monitor_modes: assert property (busMonitorEn ==
		(modeState inside {tmc_pkg::modeStandby, tmc_pkg::modeGoSleep, tmc_pkg::modeSleep})) else $error("bus monitor wrong");
	a_standby_request: assert property (modeState == tmc_pkg::modeStandby && !holdOffLatched |-> powerRequestOe)
		else $error("request off in standby");
	a_wake_low_rxd: assert property ((modeState == tmc_pkg::modeStandby && wakeRequestFlag && rxdOe)[*2] |-> !rxdOut)
		else $error("wake not shown on receive line");
	a_normal_clears: assert property (modeState == tmc_pkg::modeNormal && $past(modeState) != tmc_pkg::modeNormal |->
		##[0:1] !powerOnFlag && !wakeRequestFlag) else $error("flags not cleared in normal");
	a_holdoff_silent: assert property ($changed(holdOffLatched) |-> (modeState inside {tmc_pkg::modeSilent,
		tmc_pkg::modeOff}) || ($past(modeState) inside {tmc_pkg::modeSilent, tmc_pkg::modeOff})) else $error("hold-off moved");
	a_protected: assert property (batteryUndervoltage[*6] |-> modeState == tmc_pkg::modeOff && !rxdOe && !powerRequestOe)
		else $error("not protected on battery loss");

	// main scenarios reached
	c_gosleep: cover property (inGs ##1 modeState == tmc_pkg::modeSleep);
	c_pin_exit: cover property ($rose(standbySelectN) && enable ##[1:10] modeState == tmc_pkg::modeNormal);
	c_wake: cover property (modeState == tmc_pkg::modeStandby && wakeRequestFlag);
endmodule : tmc_mode_monitor

// ==== transceiver_mode_controller_tb.sv ====
// self-checking bench: host and device ends joined by the pin link
`timescale 1ns/10ps
module transceiver_mode_controller_tb;
	localparam int FS = 200;   // shortened fail-safe count
	logic               ref_clk = 1'b0;
	logic               rstn    = 1'b0;
	// bus master side; select tied, one slave only
	logic               hsel    = 1'b1;
	logic               hwrite  = 1'b0;
	logic [1:0]         htrans  = 2'h0;
	logic [31:0]        haddr   = 32'h0;
	logic [31:0]        hwdata  = 32'h0;
	logic               hreadyout;
	logic               hresp;
	logic [31:0]        hrdata;
	// device status inputs
	logic               batUv = 1'b0;
	logic               coreBelow = 1'b0;
	logic               ioAbove = 1'b1;
	logic               wakeEv = 1'b0;
	logic               busRec = 1'b1;
	// device outputs
	logic               driverEn, receiverEn, busMonitorEn, powerRequestOe;
	logic               wakeRequestFlag, powerOnFlag, holdOffLatched;
	tmc_pkg::tmc_mode_t modeState;
	int                 n_errors = 0;
	int                 total_checks = 0;
	int                 cycles = 0;
	logic [31:0]        rd;

	tmc_pin_if pinIf();
	tmc_host i_tmc_host (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pinIf));
	tmc_device #(.FAIL_SAFE_CYCLES(FS)) i_tmc_device (.ref_clk(ref_clk), .rstn(rstn), .pins(pinIf),
		.batteryUndervoltage(batUv), .coreSupplyAboveRise(1'b1), .coreSupplyBelowFall(coreBelow),
		.ioSupplyAboveRise(ioAbove), .ioSupplyBelowFall(1'b0), .thermalShutdown(1'b0), .wakeEvent(wakeEv),
		.busRecessive(busRec), .driverEn(driverEn), .receiverEn(receiverEn), .busMonitorEn(busMonitorEn),
		.powerRequestOut(), .powerRequestOe(powerRequestOe), .wakeRequestFlag(wakeRequestFlag),
		.powerOnFlag(powerOnFlag), .holdOffLatched(holdOffLatched), .modeState(modeState));
	tmc_mode_monitor #(.FAIL_SAFE_CYCLES(FS)) i_tmc_mode_monitor (.ref_clk(ref_clk), .rstn(rstn),
		.standbySelectN(pinIf.standbySelectN), .enable(pinIf.enable), .rxdOut(pinIf.rxdOut), .rxdOe(pinIf.rxdOe),
		.batteryUndervoltage(batUv), .driverEn(driverEn), .receiverEn(receiverEn), .busMonitorEn(busMonitorEn),
		.powerRequestOe(powerRequestOe), .wakeRequestFlag(wakeRequestFlag), .powerOnFlag(powerOnFlag),
		.holdOffLatched(holdOffLatched), .modeState(modeState));

	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;

	// hang guard, well above the planned run
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			end_of_test();
		end
	end

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one single transfer; entered just after a rising edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		rd = hrdata;
	endtask : ahb

	// pin levels {hold-off, enable, standby select}
	task automatic pins(input logic [2:0] v);
		ahb(1'b1, tmc_pkg::REG_CTRL, {29'h0, v});
	endtask : pins

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// bounded wait for a mode, then compare
	task automatic wait_mode(input tmc_pkg::tmc_mode_t m, input int lim);
		int i = 0;
		while (modeState !== m && i < lim) begin
			@(posedge ref_clk);
			i++;
		end
		check(32'(modeState), 32'(m));
	endtask : wait_mode

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		cyc(20);
		rstn <= 1'b1;
		wait_mode(tmc_pkg::modeStandby, 20);
		check(32'(powerOnFlag & busMonitorEn & ~driverEn), 32'h1);
		ahb(1'b1, 8'h08, 32'hffff_ffff);
		ahb(1'b0, 8'h08, 32'h0);
		check(rd, 32'h0);
		ahb(1'b0, tmc_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h0);
		pins(3'b011);
		wait_mode(tmc_pkg::modeNormal, 600);
		check(32'(driverEn & receiverEn & ~powerOnFlag), 32'h1);
		// silent from normal: receive only, no fail-safe, hold-off latched
		pins(3'b101);
		wait_mode(tmc_pkg::modeSilent, 40);
		busRec <= 1'b0;
		cyc(10);
		check(32'(pinIf.rxdLine | driverEn), 32'h0);
		busRec <= 1'b1;
		cyc(300);
		check(32'(modeState), 32'(tmc_pkg::modeSilent));
		check(32'(holdOffLatched), 32'h1);
		pins(3'b111);
		wait_mode(tmc_pkg::modeNormal, 40);
		check(32'(holdOffLatched), 32'h1);
		// go-to-sleep keeps the request, sleep drops it
		pins(3'b110);
		wait_mode(tmc_pkg::modeGoSleep, 20);
		check(32'(powerRequestOe), 32'h1);
		wait_mode(tmc_pkg::modeSleep, 220);
		check(32'(powerRequestOe), 32'h0);
		// select rise refused without io supply
		ioAbove <= 1'b0;
		pins(3'b111);
		cyc(600);
		check(32'(modeState), 32'(tmc_pkg::modeSleep));
		pins(3'b110);
		cyc(10);
		ioAbove <= 1'b1;
		cyc(10);
		pins(3'b111);
		wait_mode(tmc_pkg::modeNormal, 600);
		// core undervoltage past the filter, then exit to silent
		coreBelow <= 1'b1;
		cyc(3900);
		check(32'(modeState), 32'(tmc_pkg::modeNormal));
		wait_mode(tmc_pkg::modeSleep, 300);
		coreBelow <= 1'b0;
		pins(3'b100);
		pins(3'b101);
		wait_mode(tmc_pkg::modeSilent, 600);
		// wake in sleep, then fail-safe expiry from standby
		pins(3'b110);
		wait_mode(tmc_pkg::modeSleep, 240);
		wakeEv <= 1'b1;
		wait_mode(tmc_pkg::modeStandby, 20);
		wakeEv <= 1'b0;
		cyc(5);
		ahb(1'b0, tmc_pkg::REG_STATUS, 32'h0);
		check(32'(rd[tmc_pkg::STAT_RXD_BIT]), 32'h0);
		cyc(140);
		check(32'(modeState), 32'(tmc_pkg::modeStandby));
		wait_mode(tmc_pkg::modeSleep, 100);
		pins(3'b100);
		pins(3'b101);
		cyc(420);
		check(32'(modeState), 32'(tmc_pkg::modeSleep));
		pins(3'b111);
		wait_mode(tmc_pkg::modeNormal, 40);
		check(32'(wakeRequestFlag), 32'h0);
		// silent from standby keeps the timer; sleep entered with select high
		pins(3'b101);
		wait_mode(tmc_pkg::modeSilent, 40);
		pins(3'b100);
		wait_mode(tmc_pkg::modeStandby, 40);
		pins(3'b101);
		wait_mode(tmc_pkg::modeSilent, 40);
		wait_mode(tmc_pkg::modeSleep, 220);
		pins(3'b111);
		cyc(50);
		check(32'(modeState), 32'(tmc_pkg::modeSleep));
		pins(3'b100);
		pins(3'b110);
		pins(3'b111);
		cyc(420);
		pins(3'b101);
		wait_mode(tmc_pkg::modeSilent, 40);
		// battery loss: protected, latch cleared
		batUv <= 1'b1;
		wait_mode(tmc_pkg::modeOff, 20);
		cyc(6);
		check(32'({holdOffLatched, pinIf.rxdLine, powerRequestOe}), 32'h2);
		batUv <= 1'b0;
		wait_mode(tmc_pkg::modeStandby, 20);
		check(32'(holdOffLatched), 32'h0);
		end_of_test();
	end
endmodule : transceiver_mode_controller_tb
